// [verilog/mdsc_serial_chain.sv]
`timescale 1ns/1ps
module mdsc_serial_chain
	import mdsc_pkg::*;
#(
	parameter int unsigned BASE_PERIOD = BASE_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Serial pins
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic chain_in_i,
	output logic dout_o,
	output logic dout_oe_o,
	// Conversion control pins
	input wire logic start_pin_i,
	output logic data_ready_n_o,
	// Clock source pins
	input wire logic clock_source_select_pin_i,
	output logic osc_run_o,
	output logic clk_out_oe_o,
	// Configuration bits
	input wire logic chain_enable_i,
	input wire logic clk_out_enable_i,
	input wire logic [2:0] data_rate_select_i,
	// Conversion frames from the converter core
	input wire logic frame_valid_i,
	output logic frame_ready_o,
	input wire logic [FRAME_W-1:0] frame_data_i
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic [1:0] sclk_hist_q;
	logic start_prev_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_q <= 6'h01;
			sync_q <= 6'h01;
		end else begin
			meta_q <= {clock_source_select_pin_i, start_pin_i, chain_in_i,
				din_i, sclk_i, cs_n_i};
			sync_q <= meta_q;
		end
	end

	wire cs_n_s = sync_q[0];
	wire sclk_s = sync_q[1];
	wire din_s = sync_q[2];
	wire chain_s = sync_q[3];
	wire start_s = sync_q[4];
	wire clk_sel_s = sync_q[5];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sclk_hist_q <= 2'h0;
			start_prev_q <= 1'b0;
		end else begin
			sclk_hist_q <= {sclk_hist_q[0], sclk_s};
			start_prev_q <= start_s;
		end
	end

	wire sclk_rise = (sclk_hist_q == 2'h1) && !cs_n_s;
	wire sclk_fall = (sclk_hist_q == 2'h2) && !cs_n_s;
	wire start_rise = start_s && !start_prev_q;
	wire start_fall = !start_s && start_prev_q;

	// ----------------------------------------
	// Command decode on shared input
	// ----------------------------------------
	logic [2:0] cmd_cnt_q;
	logic [7:0] cmd_sh_q;
	logic cmd_hit_q;
	wire [7:0] cmd_next = {cmd_sh_q[6:0], din_s};
	wire cmd_byte_done = sclk_fall && (cmd_cnt_q == CMD_LAST_BIT);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_cnt_q <= 3'h0;
			cmd_sh_q <= 8'h00;
			cmd_hit_q <= 1'b0;
		end else begin
			cmd_cnt_q <= cs_n_s ? 3'h0 : (sclk_fall ? 3'(cmd_cnt_q + 1'b1) : cmd_cnt_q);
			cmd_sh_q <= sclk_fall ? cmd_next : cmd_sh_q;
			cmd_hit_q <= cmd_byte_done && (cmd_next == CMD_START);
		end
	end

	// ----------------------------------------
	// Conversion timing
	// ----------------------------------------
	mdsc_state_t state_q;
	logic [TMR_W-1:0] tmr_q;
	logic pend_q;
	wire sync_start = start_rise || (cmd_hit_q && !start_s);
	wire [TMR_W-1:0] period = TMR_W'(BASE_PERIOD << data_rate_select_i);
	wire conv_tick = (state_q == ST_RUN) && (tmr_q == TMR_W'(period - 1));

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			tmr_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					state_q <= sync_start ? ST_RUN : ST_IDLE;
				end
				ST_RUN: begin
					state_q <= (start_fall && !sync_start) ? ST_IDLE : ST_RUN;
				end
			endcase
			// Restart aligns all devices started together
			tmr_q <= (sync_start || conv_tick || state_q == ST_IDLE) ? '0
				: TMR_W'(tmr_q + 1'b1);
		end
	end

	// ----------------------------------------
	// Frame buffer and shifter
	// ----------------------------------------
	logic buf_valid;
	logic [FRAME_W-1:0] buf_data;
	wire load = pend_q && buf_valid && cs_n_s;

	mdsc_frame_buf u_buf (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(frame_valid_i),
		.in_ready_o(frame_ready_o),
		.in_data_i(frame_data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(load),
		.out_data_o(buf_data)
	);

	logic [FRAME_W-1:0] fr_q;
	logic [7:0] len_q;
	logic [8:0] bit_cnt_q;
	logic chain_dly_q;
	logic dout_q;
	logic data_ready_n_n_q;

	wire res_lo = (data_rate_select_i <= RES_LO_MAX_DR);
	wire [7:0] len_d = load ? (res_lo ? FRAME_LEN_LO : FRAME_LEN_HI)
		: len_q;
	// Only conversion frames travel down the chain
	wire fwd_bit = chain_enable_i ? chain_dly_q : 1'b0;
	wire [FRAME_W-1:0] fr_d = load ? buf_data
		: (sclk_rise ? {fr_q[FRAME_W-2:0], fwd_bit} : fr_q);
	wire [7:0] top_idx = 8'(len_d - 1'b1);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_q <= 1'b0;
			fr_q <= '0;
			len_q <= FRAME_LEN_HI;
			bit_cnt_q <= 9'h000;
			chain_dly_q <= 1'b0;
			dout_q <= 1'b0;
			data_ready_n_n_q <= 1'b1;
		end else begin
			// Stopped runs drop a stale conversion, keeping restart aligned
			pend_q <= conv_tick || (pend_q && !load && state_q == ST_RUN);
			fr_q <= fr_d;
			len_q <= len_d;
			if (load) begin
				bit_cnt_q <= 9'h000;
			end else if (sclk_rise && bit_cnt_q != BIT_CNT_MAX) begin
				bit_cnt_q <= 9'(bit_cnt_q + 1'b1);
			end
			// Sampled on the shift edge; zero is the separating bit
			chain_dly_q <= load ? 1'b0 : (sclk_rise ? chain_s : chain_dly_q);
			dout_q <= fr_d[top_idx];
			data_ready_n_n_q <= load ? 1'b0 : (sclk_rise ? 1'b1 : data_ready_n_n_q);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dout_o = dout_q;
	assign dout_oe_o = !cs_n_s;
	assign data_ready_n_o = data_ready_n_n_q;
	assign osc_run_o = clk_sel_s;
	assign clk_out_oe_o = clk_sel_s && clk_out_enable_i
		&& !chain_enable_i;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [TMR_W:0] since_q;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			since_q <= '0;
		end else begin
			since_q <= sync_start ? '0 : (TMR_W+1)'(since_q + 1'b1);
		end
	end

	sequence frame_loaded_s;
		load ##1 !data_ready_n_o;
	endsequence

	oe_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(cs_n_s) |-> !dout_oe_o)
		else $error("output driven while deselected");
	chain_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(sclk_rise && !chain_enable_i) |=> fr_q[0] == 1'b0)
		else $error("chain bits forwarded in standard mode");
	dont_care_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(sclk_rise && bit_cnt_q == 9'(len_q - 1'b1)) |=> dout_o == 1'b0)
		else $error("separating bit not zero");
	frame_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		load |=> len_q == (res_lo ? FRAME_LEN_LO : FRAME_LEN_HI) ||
			$changed(data_rate_select_i))
		else $error("frame length wrong for data rate");
	start_delay_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(conv_tick && since_q < (TMR_W+1)'(period)) |->
			since_q == (TMR_W+1)'(period - 1))
		else $error("first conversion not at fixed delay");
	data_ready_n_fall_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		load |-> frame_loaded_s)
		else $error("data ready did not fall on frame load");
	clk_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		chain_enable_i |-> !clk_out_oe_o)
		else $error("oscillator driven out in chain mode");
	start_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cmd_hit_q && !start_s) |=> state_q == ST_RUN && tmr_q == '0)
		else $error("start command did not start conversions");
	forward_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(sclk_rise && chain_enable_i) |=>
			fr_q[0] == $past(chain_dly_q) &&
			chain_dly_q == $past(chain_s))
		else $error("chain bit not forwarded in order");

endmodule // mdsc_serial_chain

// [verilog/mdsc_pkg.sv]
// Functional notes
// - Chip select high puts the serial data output in high impedance.
// - Chained output only when the chain enable configuration bit is set.
// - Chained: own frame, one don't-care bit, then the chain input bits.
// - Frame is 24 status bits plus eight channels times 16 or 24 bits.
// - Data-rate selection field sets the sample resolution in the frame.
// - In a chain only device 0 returns registers; others return data only.
// - Shared chip select: every write reaches all chained devices alike.
// - Chained: internal oscillator output stays off; host supplies clock.
// - Start rise to data-ready fall is a fixed count per data rate.
// - Clock master runs oscillator on select pin high, drives it if enabled.
// - With start pin low, the start command begins and syncs conversions.
package mdsc_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int unsigned STATUS_BITS = 24;
	localparam int unsigned NUM_CHAN = 8;
	localparam int unsigned RES_LO = 16;
	localparam int unsigned RES_HI = 24;
	localparam int unsigned FRAME_W = STATUS_BITS + NUM_CHAN * RES_HI;
	localparam logic [7:0] FRAME_LEN_LO = 8'(STATUS_BITS + NUM_CHAN * RES_LO);
	localparam logic [7:0] FRAME_LEN_HI = 8'(FRAME_W);
	localparam logic [2:0] RES_LO_MAX_DR = 3'h1;
	localparam int unsigned BUF_DEPTH = 2;

	// ----------------------------------------
	// Serial commands and counters
	// ----------------------------------------
	localparam logic [7:0] CMD_START = 8'h08;
	localparam logic [2:0] CMD_LAST_BIT = 3'h7;
	localparam logic [8:0] BIT_CNT_MAX = 9'h1ff;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned FASTEST_RATE_HZ = 64_000;
	localparam int unsigned BASE_PERIOD_CYC = CLK_HZ / FASTEST_RATE_HZ;
	localparam int unsigned TMR_W = 17;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} mdsc_state_t;

endpackage

// [verilog/mdsc_frame_buf.sv]
`timescale 1ns/1ps
module mdsc_frame_buf
	import mdsc_pkg::*;
#(
	parameter int unsigned W = FRAME_W,
	parameter int unsigned DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= push ? PW'(wr_q + 1'b1) : wr_q;
			rd_q <= pop ? PW'(rd_q + 1'b1) : rd_q;
			cnt_q <= (PW+1)'(cnt_q + push - pop);
		end
	end

	buf_full_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cnt_q == (PW+1)'(DEPTH)) |-> !in_ready_o)
		else $error("buffer accepts while full");

endmodule // mdsc_frame_buf

// [tb/mdsc_next_dev.sv]
`timescale 1ns/1ps
module mdsc_next_dev #(
	parameter logic [15:0] PATTERN = 16'hc3a5
) (
	// Shared serial pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	// Chain output toward the device under test
	output logic chain_o
);
	logic [15:0] sh_q;

	// ----------------------------------------
	// Shift on falls, steady at the next rise
	// ----------------------------------------
	always @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sh_q <= PATTERN;
		end else begin
			// Last in chain: grounded chain input feeds zeros
			sh_q <= {sh_q[14:0], 1'b0};
		end
	end

	// Released line shows the inverse, never a stale bit
	assign chain_o = cs_n_i ? ~sh_q[15] : sh_q[15];
endmodule // mdsc_next_dev

// [tb/multi_device_serial_chain_test.sv]
`timescale 1ns/1ps
module multi_device_serial_chain_test;
	import mdsc_pkg::*;
	localparam int unsigned BP = 8;
	localparam logic [FRAME_W-1:0] FA = {9{24'h5a3c96}};
	localparam logic [FRAME_W-1:0] FB = {9{24'hc96a53}};
	localparam logic [FRAME_W-1:0] FC = {9{24'h3e81d4}};
	localparam logic [15:0] PAT = 16'hc3a5;
	logic clk_i = 0, sys_rst_i = 1, cs_n_i = 1, sclk_i = 0, din_i = 0;
	logic start_pin_i = 0, sel = 0, chain_en = 0, clk_en = 0, fv = 0;
	logic [2:0] dr = 3'h0;
	logic [FRAME_W-1:0] fd = '0;
	logic chain_in, dout_o, dout_oe_o, data_ready_n_n, osc_run, clk_oe, f_rdy;
	int err_total = 0, checked = 0, n;

	mdsc_serial_chain #(.BASE_PERIOD(BP)) uut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
		.din_i(din_i), .chain_in_i(chain_in), .dout_o(dout_o),
		.dout_oe_o(dout_oe_o), .start_pin_i(start_pin_i),
		.data_ready_n_o(data_ready_n_n), .clock_source_select_pin_i(sel),
		.osc_run_o(osc_run), .clk_out_oe_o(clk_oe),
		.chain_enable_i(chain_en), .clk_out_enable_i(clk_en),
		.data_rate_select_i(dr), .frame_valid_i(fv),
		.frame_ready_o(f_rdy), .frame_data_i(fd));
	mdsc_next_dev #(.PATTERN(PAT)) nxt (.sclk_i(sclk_i), .cs_n_i(cs_n_i),
		.chain_o(chain_in));

	initial forever #12.5 clk_i = ~clk_i;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask
	task pulse;
		sclk_i = 1;
		tick(4);
		sclk_i = 0;
		tick(4);
	endtask
	task rd(input logic [FRAME_W-1:0] f, input int len);
		for (int i = 0; i < len; i++) begin
			chk(dout_o, f[len-1-i]);
			pulse;
		end
	endtask
	task wait_rdy;
		n = 0;
		while (data_ready_n_n !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		chk(n < 400, 1);
	endtask
	task tally_and_finish;
		$display("mismatches %0d in %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_pins;
		for (int k = 0; k < 8; k++) begin
			{sel, clk_en, chain_en} = k[2:0];
			tick(3);
			chk(osc_run, sel);
			chk(clk_oe, sel & clk_en & ~chain_en);
		end
		chain_en = 0;
		chk(dout_oe_o, 0);
	endtask
	task t_buf;
		fd = FA;
		fv = 1;
		tick(1);
		fd = FB;
		tick(1);
		chk(f_rdy, 0);
		fd = FC;
		tick(2);
		fv = 0;
	endtask
	task t_std;
		start_pin_i = 1;
		wait_rdy;
		chk(n >= BP && n <= BP + 8, 1);
		cs_n_i = 0;
		tick(4);
		chk(dout_oe_o, 1);
		rd(FA, 152);
		for (int i = 0; i < 4; i++) begin
			chk(dout_o, 0);
			pulse;
		end
		cs_n_i = 1;
		tick(4);
		chk(dout_oe_o, 0);
		wait_rdy;
		start_pin_i = 0;
		tick(4);
		chk(f_rdy, 1);
	endtask
	task t_chain;
		logic [7:0] cmd;
		cmd = CMD_START;
		chain_en = 1;
		dr = 3'h2;
		fd = FC;
		fv = 1;
		tick(1);
		fv = 0;
		cs_n_i = 0;
		for (int i = 7; i >= 0; i--) begin
			din_i = cmd[i];
			pulse;
		end
		din_i = 0;
		cs_n_i = 1;
		tick(4);
		wait_rdy;
		cs_n_i = 0;
		tick(4);
		rd(FC, 216);
		chk(dout_o, 0);
		pulse;
		for (int i = 0; i < 16; i++) begin
			chk(dout_o, PAT[15-i]);
			pulse;
		end
		cs_n_i = 1;
	endtask

	initial begin
		#1ms;
		err_total++;
		tally_and_finish;
	end

	initial begin
		repeat (6) @(posedge clk_i);
		#2;
		sys_rst_i = 0;
		tick(3);
		t_pins;
		t_buf;
		t_std;
		t_chain;
		tally_and_finish;
	end
endmodule // multi_device_serial_chain_test
